// ==== rtl/lcd_top.sv ====
// cascaded output dividers of channel 3 and stage 1 of channel 4, with AXI4-Lite registers
// assumes dist_clk_i is the distribution clock sampled as a level on
// clk_sys_i, and sync_i the chip-level synchronisation level
//
// Operation
// R1: channel 3 stage 1 low time is upper count nibble plus one cycles
// R2: channel 3 stage 1 high time is lower count nibble plus one cycles
// R3: count field zero gives one-cycle phase; all counts reset to zero
// R4: channel 3 stage 2 low/high minus one from upper/lower nibbles
// R5: channel 4 stage 1 low minus one from upper nibble, own input
// R6: channel 4 stage 1 high minus one from lower nibble
// R7: channel 3 phase offsets: stage 2 upper, stage 1 lower, reset zero
// R8: channel 4 stage 2 phase offset in upper nibble, reset zero
// R9: control bit 5 bypasses and powers down channel 3 stage 2
// R10: control bit 4 bypasses and powers down channel 3 stage 1
// R11: control bit 3 set makes channel 3 ignore chip-level sync
// R12: bit 2 forces channel 3 output level; needs sync-ignore set too
// R13: bit 1 chooses channel 3 stage 2 starting level
// R14: bit 0 chooses channel 3 stage 1 starting level
// R15: correction bit 0 clear enables duty correction, set disables
// R16: divider period is sum of low and high durations
//
// Register access over AXI4-Lite is this design's own decision.
module lcd_top
  import lcd_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  input  wire lcd_pkg::lcd_axi_req_t axi_req_i,
  output lcd_pkg::lcd_axi_rsp_t      axi_rsp_o,
  input  wire logic                  dist_clk_i,
  input  wire logic                  sync_i,
  output logic                       ch3_stage1_o,
  output logic                       ch3_out_o,
  output logic                       ch4_stage1_o,
  output logic                       ch3_dcc_en_o
);
  import lcd_pkg::*;

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic [7:0]        c3s1_cnt;
    logic [7:0]        c3_phase;
    logic [7:0]        c3s2_cnt;
    logic [5:0]        c3_ctrl;
    logic              c3_dcc_on;
    logic [7:0]        c4s1_cnt;
    logic [3:0]        c4_phase2;
    lcd_div_t          c3s1;
    lcd_div_t          c3s2;
    lcd_div_t          c4s1;
    logic              out3;
    logic              armed;
    logic              aw_got;
    logic              w_got;
    logic [LCD_AW-1:0] aw_addr;
    logic [31:0]       w_data;
    logic              w_lane0;
    lcd_axi_rsp_t      rsp;
  } lcd_state_t;

  localparam lcd_state_t LCD_STATE_RST = '{
    c3s1_cnt:   LCD_RST_CNT,
    c3_phase:   LCD_RST_PHASE,
    c3s2_cnt:   LCD_RST_CNT,
    c3_ctrl:    LCD_RST_CTRL,
    c3_dcc_on:  ~LCD_RST_DCC,
    c4s1_cnt:   LCD_RST_CNT,
    c4_phase2:  4'h0,
    c3s1:       '0,
    c3s2:       '0,
    c4s1:       '0,
    out3:       1'b0,
    armed:      1'b0,
    aw_got:     1'b0,
    w_got:      1'b0,
    aw_addr:    '0,
    w_data:     '0,
    w_lane0:    1'b0,
    rsp:        '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                  bresp: LCD_RESP_OKAY, rresp: LCD_RESP_OKAY,
                  bvalid: 1'b0, rvalid: 1'b0, rdata: 32'h0000_0000}
  };

  lcd_state_t s_q;
  lcd_state_t s_d;

  // ==========================================================
  // divider stage
  // ==========================================================
  // one rising edge of the stage input is one input cycle; a held or
  // bypassed stage reloads so it starts cleanly on release
  function automatic lcd_div_t div_step(
    input lcd_div_t   d,
    input logic       in_lvl,
    input logic [3:0] lo,
    input logic [3:0] hi,
    input logic [3:0] ph,
    input logic       byp,
    input logic       hold,
    input logic       st_hi
  );
    lcd_div_t n;
    n      = d;
    n.in_q = in_lvl;
    if (byp) begin
      // bypass: input straight to output, count logic idle
      n.lvl = in_lvl;
      n.cnt = {1'b0, st_hi ? hi : lo} + {1'b0, ph};
    end else if (hold) begin
      // start level and first phase stretched by the offset
      n.lvl = st_hi;
      n.cnt = {1'b0, st_hi ? hi : lo} + {1'b0, ph};
    end else if (in_lvl && !d.in_q) begin
      // R3: zero count toggles on the first edge
      if (d.cnt == 5'h00) begin
        n.lvl = ~d.lvl;
        // R16: next phase loads its own count
        n.cnt = {1'b0, d.lvl ? lo : hi};
      end else begin
        n.cnt = d.cnt - 5'h01;
      end
    end
    return n;
  endfunction

  // ==========================================================
  // register read data
  // ==========================================================
  function automatic logic [31:0] rd_mux(
    input lcd_state_t   s,
    input logic [LCD_AW-1:0] a
  );
    logic [11:0] idx;
    logic [31:0] v;
    idx = {2'b00, a[LCD_AW-1:2]};
    v   = 32'h0000_0000;
    case (idx)
      LCD_IDX_C3S1_CNT: v[7:0] = s.c3s1_cnt;
      LCD_IDX_C3_PHASE: v[7:0] = s.c3_phase;
      LCD_IDX_C3S2_CNT: v[7:0] = s.c3s2_cnt;
      LCD_IDX_C3_CTRL:  v[5:0] = s.c3_ctrl;
      LCD_IDX_C3_DCC:   v[LCD_DCC_DIS] = ~s.c3_dcc_on;
      LCD_IDX_C4S1_CNT: v[7:0] = s.c4s1_cnt;
      LCD_IDX_C4_PHASE: v[7:4] = s.c4_phase2;
      LCD_IDX_STATUS:   v[3:0] = {s.c4s1.lvl, s.out3,
                                  s.c3s2.lvl, s.c3s1.lvl};
      default:          v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [LCD_AW-1:0] a);
    logic [11:0] idx;
    idx = {2'b00, a[LCD_AW-1:2]};
    return (idx >= LCD_IDX_C3S1_CNT && idx <= LCD_IDX_C4_PHASE) ||
           (idx == LCD_IDX_STATUS);
  endfunction

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    logic       hold3;
    logic       wr_now;
    logic [11:0] widx;
    s_d    = s_q;
    hold3  = 1'b0;
    wr_now = 1'b0;
    widx   = 12'h000;

    // write address and data, taken in either order
    if (axi_req_i.awvalid && s_q.rsp.awready) begin
      s_d.aw_got      = 1'b1;
      s_d.aw_addr     = axi_req_i.awaddr;
      s_d.rsp.awready = 1'b0;
    end
    if (axi_req_i.wvalid && s_q.rsp.wready) begin
      s_d.w_got      = 1'b1;
      s_d.w_data     = axi_req_i.wdata;
      s_d.w_lane0    = axi_req_i.wstrb[0];
      s_d.rsp.wready = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid) begin
      wr_now          = 1'b1;
      widx            = {2'b00, s_q.aw_addr[LCD_AW-1:2]};
      s_d.aw_got      = 1'b0;
      s_d.w_got       = 1'b0;
      s_d.rsp.bvalid  = 1'b1;
      s_d.rsp.bresp   = mapped(s_q.aw_addr) ? LCD_RESP_OKAY
                                            : LCD_RESP_SLVERR;
    end
    if (s_q.rsp.bvalid && axi_req_i.bready) begin
      s_d.rsp.bvalid  = 1'b0;
      s_d.rsp.awready = 1'b1;
      s_d.rsp.wready  = 1'b1;
    end

    // only byte lane 0 carries register bits
    if (wr_now && s_q.w_lane0) begin
      case (widx)
        // R1: stage 1 low and high counts, channel 3
        LCD_IDX_C3S1_CNT: s_d.c3s1_cnt = s_q.w_data[7:0];
        // R7: both channel 3 phase offsets
        LCD_IDX_C3_PHASE: s_d.c3_phase = s_q.w_data[7:0];
        // R4: stage 2 counts, channel 3
        LCD_IDX_C3S2_CNT: s_d.c3s2_cnt = s_q.w_data[7:0];
        LCD_IDX_C3_CTRL:  s_d.c3_ctrl  = s_q.w_data[5:0];
        // R15: correction disable flag
        LCD_IDX_C3_DCC:   s_d.c3_dcc_on = ~s_q.w_data[LCD_DCC_DIS];
        // R5: stage 1 counts, channel 4
        LCD_IDX_C4S1_CNT: s_d.c4s1_cnt = s_q.w_data[7:0];
        // R8: channel 4 stage 2 offset, low nibble reads zero
        LCD_IDX_C4_PHASE: s_d.c4_phase2 = s_q.w_data[7:4];
        default:          s_d.c4_phase2 = s_q.c4_phase2;
      endcase
    end

    // read: one request at a time, answer one cycle after it is taken
    if (axi_req_i.arvalid && s_q.rsp.arready) begin
      s_d.rsp.arready = 1'b0;
      s_d.rsp.rvalid  = 1'b1;
      s_d.rsp.rdata   = rd_mux(s_q, axi_req_i.araddr);
      s_d.rsp.rresp   = mapped(axi_req_i.araddr) ? LCD_RESP_OKAY
                                                 : LCD_RESP_SLVERR;
    end
    if (s_q.rsp.rvalid && axi_req_i.rready) begin
      s_d.rsp.rvalid  = 1'b0;
      s_d.rsp.arready = 1'b1;
    end

    // R11: sync restarts channel 3 unless ignored
    hold3 = sync_i && !s_q.c3_ctrl[LCD_CTL_NOSYNC];
    // first cycle after reset only samples the divider inputs: an
    // input already high at release must not count as a rising edge
    s_d.armed = 1'b1;
    hold3     = hold3 || !s_q.armed;

    // R1: R2: R10: R14: channel 3 stage 1
    s_d.c3s1 = div_step(s_q.c3s1, dist_clk_i,
                        s_q.c3s1_cnt[LCD_LO_MSB:LCD_LO_LSB],
                        s_q.c3s1_cnt[LCD_HI_MSB:LCD_HI_LSB],
                        s_q.c3_phase[3:0],
                        s_q.c3_ctrl[LCD_CTL_BYP1], hold3,
                        s_q.c3_ctrl[LCD_CTL_START1]);

    // R4: R9: R13: channel 3 stage 2 runs on stage 1 output
    s_d.c3s2 = div_step(s_q.c3s2, s_q.c3s1.lvl,
                        s_q.c3s2_cnt[LCD_LO_MSB:LCD_LO_LSB],
                        s_q.c3s2_cnt[LCD_HI_MSB:LCD_HI_LSB],
                        s_q.c3_phase[7:4],
                        s_q.c3_ctrl[LCD_CTL_BYP2], hold3,
                        s_q.c3_ctrl[LCD_CTL_START2]);

    // R5: R6: channel 4 stage 1, always obeys sync
    s_d.c4s1 = div_step(s_q.c4s1, dist_clk_i,
                        s_q.c4s1_cnt[LCD_LO_MSB:LCD_LO_LSB],
                        s_q.c4s1_cnt[LCD_HI_MSB:LCD_HI_LSB],
                        4'h0, 1'b0, sync_i || !s_q.armed, 1'b0);

    // R12: forced level shows only while sync is up and ignored
    if (sync_i && s_q.c3_ctrl[LCD_CTL_NOSYNC]) begin
      s_d.out3 = s_q.c3_ctrl[LCD_CTL_FORCE];
    end else begin
      s_d.out3 = s_q.c3s2.lvl;
    end
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= LCD_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all straight from state flip-flops
  // ==========================================================
  assign axi_rsp_o    = s_q.rsp;
  assign ch3_stage1_o = s_q.c3s1.lvl;
  assign ch3_out_o    = s_q.out3;
  assign ch4_stage1_o = s_q.c4s1.lvl;
  // R15: enable kept in its own flop, read back inverted as the flag
  assign ch3_dcc_en_o = s_q.c3_dcc_on;

endmodule

// ==== rtl/lcd_pkg.sv ====
// constants, register map and carrier types of the channel dividers
// assumes an AXI4-Lite master with 32-bit data on the register side
package lcd_pkg;

  // ==========================================================
  // register map: printed offsets are indexes, byte = 4 * index
  // ==========================================================
  localparam int          LCD_AW            = 12;
  localparam logic [11:0] LCD_IDX_C3S1_CNT  = 12'h199;
  localparam logic [11:0] LCD_IDX_C3_PHASE  = 12'h19A;
  localparam logic [11:0] LCD_IDX_C3S2_CNT  = 12'h19B;
  localparam logic [11:0] LCD_IDX_C3_CTRL   = 12'h19C;
  localparam logic [11:0] LCD_IDX_C3_DCC    = 12'h19D;
  localparam logic [11:0] LCD_IDX_C4S1_CNT  = 12'h19E;
  localparam logic [11:0] LCD_IDX_C4_PHASE  = 12'h19F;
  localparam logic [11:0] LCD_IDX_STATUS    = 12'h1A3;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int LCD_LO_MSB        = 7;
  localparam int LCD_LO_LSB        = 4;
  localparam int LCD_HI_MSB        = 3;
  localparam int LCD_HI_LSB        = 0;
  localparam int LCD_CTL_BYP2      = 5;
  localparam int LCD_CTL_BYP1      = 4;
  localparam int LCD_CTL_NOSYNC    = 3;
  localparam int LCD_CTL_FORCE     = 2;
  localparam int LCD_CTL_START2    = 1;
  localparam int LCD_CTL_START1    = 0;
  localparam int LCD_DCC_DIS       = 0;

  // ==========================================================
  // reset values and bus answers
  // ==========================================================
  localparam logic [7:0] LCD_RST_CNT   = 8'h00;
  localparam logic [7:0] LCD_RST_PHASE = 8'h00;
  localparam logic [5:0] LCD_RST_CTRL  = 6'h00;
  localparam logic       LCD_RST_DCC   = 1'b0;
  localparam logic [1:0] LCD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LCD_RESP_SLVERR = 2'h2;

  // ==========================================================
  // carrier types
  // ==========================================================
  typedef struct packed {
    logic [LCD_AW-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [LCD_AW-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } lcd_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } lcd_axi_rsp_t;

  // one divider stage: level, remaining count, last input level
  typedef struct packed {
    logic       lvl;
    logic [4:0] cnt;
    logic       in_q;
  } lcd_div_t;

endpackage

// ==== tb/lcd_top_assertions.sv ====
// checker for the channel divider block, bound to its top-level ports
// assumes one system clock and an active-low asynchronous reset
module lcd_top_assertions
  import lcd_pkg::*;
(
  input wire logic                  clk_sys_i,
  input wire logic                  rst_n_i,
  input wire lcd_pkg::lcd_axi_req_t axi_req_i,
  input wire lcd_pkg::lcd_axi_rsp_t axi_rsp_o,
  input wire logic                  dist_clk_i,
  input wire logic                  sync_i,
  input wire logic                  ch3_stage1_o,
  input wire logic                  ch3_out_o,
  input wire logic                  ch4_stage1_o,
  input wire logic                  ch3_dcc_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import lcd_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // register bus
  // ==========================================================
  AST_B_LAT: assert property (axi_req_i.awvalid && axi_rsp_o.awready &&
    axi_req_i.wvalid && axi_rsp_o.wready |-> ##2 axi_rsp_o.bvalid)
    else $error("write answer late");
  AST_R_LAT: assert property (axi_req_i.arvalid && axi_rsp_o.arready
    |=> axi_rsp_o.rvalid) else $error("read answer late");
  AST_B_BLOCK: assert property (axi_rsp_o.bvalid |->
    !axi_rsp_o.awready && !axi_rsp_o.wready) else $error("write not held");
  AST_R_DROP: assert property (axi_rsp_o.rvalid && axi_req_i.rready
    |=> !axi_rsp_o.rvalid) else $error("read answer stuck");
  AST_SLV_DATA: assert property (axi_rsp_o.rvalid &&
    axi_rsp_o.rresp == LCD_RESP_SLVERR |-> axi_rsp_o.rdata == 32'h0)
    else $error("refused read returned data");

  // ==========================================================
  // divider outputs
  // ==========================================================
  // correction on at start
  AST_DCC_RST: assert property (!$past(rst_n_i) |-> ch3_dcc_en_o)
    else $error("correction off after reset");
  AST_DCC_CHG: assert property ($changed(ch3_dcc_en_o) |->
    $rose(axi_rsp_o.bvalid)) else $error("correction moved alone");
  AST_CH4_EDGE: assert property ($changed(ch4_stage1_o) &&
    $past(rst_n_i, 2) && !$past(sync_i) && !$past(sync_i, 2)
    |-> $past(dist_clk_i) && !$past(dist_clk_i, 2))
    else $error("divider stepped without input rise");
  AST_CH4_SYNC: assert property (sync_i |=> !ch4_stage1_o)
    else $error("divider ran during sync");

  cover property (axi_rsp_o.bvalid && axi_rsp_o.bresp == LCD_RESP_SLVERR);
  cover property ($rose(ch3_out_o));
  cover property ($rose(ch4_stage1_o));
endmodule

bind lcd_top lcd_top_assertions u_chk (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o),
  .dist_clk_i(dist_clk_i), .sync_i(sync_i), .ch3_stage1_o(ch3_stage1_o),
  .ch3_out_o(ch3_out_o), .ch4_stage1_o(ch4_stage1_o),
  .ch3_dcc_en_o(ch3_dcc_en_o));

// ==== tb/lcd_top_tb.sv ====
// self-checking bench for the channel dividers and their registers
// assumes the divider input toggles every two system clocks
module lcd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lcd_pkg::*;

  logic         clk_sys_i  = 1'b0;
  logic         rst_n_i    = 1'b0;
  lcd_axi_req_t axi_req    = '0;
  lcd_axi_rsp_t axi_rsp;
  logic         dist_clk_i = 1'b0;
  logic         sync_i     = 1'b0;
  logic [1:0]   dcnt       = 2'h0;
  logic         ch3_stage1, ch3_out, ch4_stage1, ch3_dcc_en;
  int           miscompares = 0;
  int           n_compared  = 0;
  int           cyc         = 0;

  lcd_top u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .axi_req_i(axi_req), .axi_rsp_o(axi_rsp), .dist_clk_i(dist_clk_i),
    .sync_i(sync_i), .ch3_stage1_o(ch3_stage1), .ch3_out_o(ch3_out),
    .ch4_stage1_o(ch4_stage1), .ch3_dcc_en_o(ch3_dcc_en));

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // one input cycle is four system clocks
  always @(posedge clk_sys_i) begin
    dcnt       <= dcnt + 2'h1;
    dist_clk_i <= dcnt[1];
    cyc        <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ==========================================================
  // tasks
  // ==========================================================
  task end_of_test;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task axi_wr(input logic [11:0] idx, input logic [31:0] d,
              input logic [1:0] er);
    int t;
    @(posedge clk_sys_i);
    axi_req.awaddr  <= {idx[9:0], 2'b00};
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid  <= 1'b1;
    axi_req.bready  <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys_i);
      t++;
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid && t < 50);
    axi_req.bready <= 1'b0;
    chk(32'(axi_rsp.bvalid), 32'h1);
    chk(32'(axi_rsp.bresp), 32'(er));
  endtask

  task axi_rd(input logic [11:0] idx, input logic [31:0] ed,
              input logic [1:0] er);
    int t;
    @(posedge clk_sys_i);
    axi_req.araddr  <= {idx[9:0], 2'b00};
    axi_req.arvalid <= 1'b1;
    axi_req.rready  <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys_i);
      t++;
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid && t < 50);
    axi_req.rready <= 1'b0;
    chk(32'(axi_rsp.rvalid), 32'h1);
    chk(axi_rsp.rdata, ed);
    chk(32'(axi_rsp.rresp), 32'(er));
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return ch3_stage1;
      1: return ch3_out;
      default: return ch4_stage1;
    endcase
  endfunction

  // high then low time in system clocks; settles first, counts reload late
  task meas(input int sel, input int eh, input int el);
    int t, h, l;
    repeat (60) @(posedge clk_sys_i);
    t = 0;
    while (pick(sel) !== 1'b0 && t < 300) begin
      @(posedge clk_sys_i);
      t++;
    end
    while (pick(sel) !== 1'b1 && t < 600) begin
      @(posedge clk_sys_i);
      t++;
    end
    h = 0;
    l = 0;
    while (pick(sel) === 1'b1 && h < 300) begin
      @(posedge clk_sys_i);
      h++;
    end
    while (pick(sel) === 1'b0 && l < 300) begin
      @(posedge clk_sys_i);
      l++;
    end
    chk(h, eh);
    chk(l, el);
  endtask

  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 'h199; i <= 'h19F; i++)
      axi_rd(12'(i), 32'h0, LCD_RESP_OKAY);
    axi_rd(12'h1A0, 32'h0, LCD_RESP_SLVERR);
    axi_wr(12'h1A0, 32'hFF, LCD_RESP_SLVERR);
    chk(32'(ch3_dcc_en), 32'h1);
    $display("test reset values done");
    axi_wr(LCD_IDX_C3_PHASE, 32'hA5, LCD_RESP_OKAY);
    axi_rd(LCD_IDX_C3_PHASE, 32'hA5, LCD_RESP_OKAY);
    axi_wr(LCD_IDX_C4_PHASE, 32'hA5, LCD_RESP_OKAY);
    axi_rd(LCD_IDX_C4_PHASE, 32'hA0, LCD_RESP_OKAY);
    axi_wr(LCD_IDX_C3_DCC, 32'h1, LCD_RESP_OKAY);
    chk(32'(ch3_dcc_en), 32'h0);
    axi_wr(LCD_IDX_C3_DCC, 32'h0, LCD_RESP_OKAY);
    $display("test register access done");
    axi_wr(LCD_IDX_C3S1_CNT, 32'h21, LCD_RESP_OKAY);
    meas(0, 8, 12);
    axi_wr(LCD_IDX_C3S1_CNT, 32'h0, LCD_RESP_OKAY);
    meas(0, 4, 4);
    axi_wr(LCD_IDX_C4S1_CNT, 32'h13, LCD_RESP_OKAY);
    meas(2, 16, 8);
    axi_wr(LCD_IDX_C3S2_CNT, 32'h10, LCD_RESP_OKAY);
    meas(1, 8, 16);
    $display("test divider counts done");
    axi_wr(LCD_IDX_C3_CTRL, 32'h20, LCD_RESP_OKAY);
    meas(1, 4, 4);
    axi_wr(LCD_IDX_C3_CTRL, 32'h30, LCD_RESP_OKAY);
    meas(0, 2, 2);
    meas(1, 2, 2);
    $display("test bypass done");
    axi_wr(LCD_IDX_C3_CTRL, 32'h03, LCD_RESP_OKAY);
    sync_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    chk(32'(ch3_stage1), 32'h1);
    chk(32'(ch3_out), 32'h1);
    chk(32'(ch4_stage1), 32'h0);
    axi_wr(LCD_IDX_STATUS, 32'h0, LCD_RESP_OKAY);
    axi_rd(LCD_IDX_STATUS, 32'h7, LCD_RESP_OKAY);
    axi_wr(LCD_IDX_C3_CTRL, 32'h04, LCD_RESP_OKAY);
    repeat (4) @(posedge clk_sys_i);
    chk(32'(ch3_out), 32'h0);
    axi_wr(LCD_IDX_C3_CTRL, 32'h0C, LCD_RESP_OKAY);
    repeat (4) @(posedge clk_sys_i);
    chk(32'(ch3_out), 32'h1);
    meas(0, 4, 4);
    axi_wr(LCD_IDX_C3_CTRL, 32'h08, LCD_RESP_OKAY);
    repeat (4) @(posedge clk_sys_i);
    chk(32'(ch3_out), 32'h0);
    sync_i <= 1'b0;
    axi_wr(LCD_IDX_C3_CTRL, 32'h0, LCD_RESP_OKAY);
    $display("test sync and force done");
    end_of_test();
  end
endmodule
